/* logic/eeprom_pkg.sv */
// Purpose: Shared constants and types of the two-wire EEPROM slave core
// Assumes: 40 MHz pclk, APB register access
// Notes: Timing counts derive from the printed times and the clock period
package eeprom_pkg;
   // Array shape
   localparam int MEM_DEPTH = 256;
   localparam int PAGE_BYTES = 16;
   // Fixed upper nibble of the slave address
   localparam logic [3:0] TYPE_CODE = 4'hA;
   // Self-timed programming, longest time rounds down
   localparam int CLK_PERIOD_NS = 25;
   localparam int PROG_TIME_NS = 5000000;
   localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
   localparam int PROG_CNT_W = 18;
   // APB map
   localparam logic [11:0] STATUS_OFS = 12'h000;
   localparam logic [11:0] CTRL_OFS = 12'h004;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
   localparam int CTRL_EN_BIT = 0;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_WP_BIT = 1;
   localparam int ST_STBY_BIT = 2;
   localparam int ST_SEL_LSB = 4;
   localparam int ST_PTR_LSB = 8;
   // Bus-side states
   typedef enum logic [2:0]
   {
      S_IDLE = 3'b000,
      S_DEV = 3'b001,
      S_DACK = 3'b010,
      S_WA = 3'b011,
      S_WACK = 3'b100,
      S_WR = 3'b101,
      S_RD = 3'b110,
      S_RACK = 3'b111
   } bus_state_t;
endpackage : eeprom_pkg

/* logic/pin_sync.sv */
// Purpose: Two-flop synchroniser for a group of pin inputs
// Assumes: Inputs are asynchronous to pclk
// Notes: Only the second stage is visible outside
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Pins in, synchronised levels out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   // First stage, read by the second stage only
   logic [W-1:0] meta_q;

   // Two flops in series
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_q <= '0;
         q <= '0;
      end
      else
      begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule : pin_sync
`default_nettype wire

/* logic/prog_timer.sv */
// Purpose: Self-timed programming cycle counter
// Assumes: start is a one-cycle pulse, ignored while busy
// Notes: done pulses once in the last cycle of busy
`timescale 1ns/1ps
`default_nettype none
module prog_timer
   import eeprom_pkg::*;
#(
   parameter int CYCLES = PROG_CYCLES
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic start,
   output logic busy,
   output logic done
);
   // Cycles left in the running cycle
   logic [PROG_CNT_W-1:0] left_q;

   // Load on start, count down to zero
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         left_q <= '0;
      else if (start && left_q == '0)
         left_q <= PROG_CNT_W'(CYCLES);
      else if (left_q != '0)
         left_q <= left_q - 1'b1;
   end

   assign busy = (left_q != '0);
   assign done = (left_q == PROG_CNT_W'(1));
endmodule : prog_timer
`default_nettype wire

/* logic/eeprom_core.sv */
// Purpose: Slave core of a 256 x 8 two-wire serial EEPROM
// Assumes: scl, sda, wp and straps are asynchronous pins
// Notes: The array is held in flops; straps need external pull-downs
// What this block does
// R1: 256 bytes, eight-bit byte address
// R2: Sixteen-byte pages bound page writes
// R3: Partial pages program only bytes sent
// R4: Self-timed programming, five milliseconds maximum
// R5: Write-protect high blocks all programming
// R6: Write-protect low lets writes proceed
// R7: Floating straps read as zero
// R8: Three straps form hardware address bits
// R9: Data line is open-drain, pull low only
// R10: Power-on reset clears state, enters standby
// R11: Reset during power-down starts no write
// R12: Stop enters standby unless programming
// R13: Master makes clock; device samples it
// R14: Master sends select, address, then data
// R15: Master waits for supply before commands
// R16: Type code, strap match, read/write bit
// R17: Stop after writes starts programming, silent
// R18: Page write increments low four bits
// R19: No address acknowledge while programming
// R20: Protected writes acknowledged, never programmed
`timescale 1ns/1ps
`default_nettype none
module eeprom_core
   import eeprom_pkg::*;
#(
   parameter int PROG_CYC = PROG_CYCLES
) (
   // Clock and power-on reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Two-wire bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Straps and protection
   input wire logic device_select_bit0,
   input wire logic device_select_bit1,
   input wire logic device_select_bit2,
   input wire logic wp_in,
   // Status
   output logic standby
);
   // Synchronised pins and previous samples
   logic [5:0] pins_s;
   logic scl_s, sda_s, wp_s;
   logic [2:0] sel_s;
   logic scl_p_q, sda_p_q;
   // Edges and bus conditions
   logic scl_rise, scl_fall, start_c, stop_c;
   // Bus state
   bus_state_t state_q;
   logic [3:0] cnt_q;
   logic [7:0] shift_q;
   logic [7:0] tx_q;
   logic [7:0] ptr_q;
   logic rw_q;
   logic drv_q;
   // Page buffer, its valid mask and page base
   logic [7:0] buf_q [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] vld_q;
   logic [3:0] page_q;
   // Array storage
   logic [7:0] mem_q [MEM_DEPTH];
   // Programming control
   logic busy, done, prog_start;
   logic dev_match;
   // Registers
   logic [31:0] ctrl_q;
   logic en;

   // Every pin passes two flops before use [R13]
   pin_sync #(.W(6)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d({wp_in, device_select_bit2, device_select_bit1, device_select_bit0, sda_in, scl_in}),
      .q(pins_s)
   );
   assign scl_s = pins_s[0];
   assign sda_s = pins_s[1];
   assign sel_s = pins_s[4:2];
   assign wp_s = pins_s[5];

   // Previous samples for edge and condition detection
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end
      else
      begin
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
      end
   end

   // Clock edges from the master's clock [R13]
   assign scl_rise = scl_s & ~scl_p_q;
   assign scl_fall = ~scl_s & scl_p_q;
   // Start: data falls with clock high; Stop: data rises with clock high
   assign start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
   assign stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;
   assign en = ctrl_q[CTRL_EN_BIT];

   // Address match; an unconnected strap arrives as zero [R7] [R8] [R16]
   assign dev_match = (shift_q[7:4] == TYPE_CODE) && (shift_q[3:1] == sel_s);

   // Programming starts only at Stop with bytes pending and no protection [R5] [R6] [R17]
   assign prog_start = stop_c && (vld_q != '0) && !wp_s && !busy;

   // Self-timed programming cycle [R4]
   prog_timer #(.CYCLES(PROG_CYC)) u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .start(prog_start),
      .busy(busy),
      .done(done)
   );

   // Bus state machine; reset returns it to idle [R10] [R11]
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= S_IDLE;
         cnt_q <= 4'h0;
         shift_q <= 8'h00;
         tx_q <= 8'h00;
         ptr_q <= 8'h00;
         rw_q <= 1'b0;
         drv_q <= 1'b0;
      end
      else if (!en || stop_c)
      begin
         // Stop releases the line and goes idle [R12]
         state_q <= S_IDLE;
         drv_q <= 1'b0;
      end
      else if (start_c)
      begin
         // Start (or repeated start) restarts address reception
         state_q <= S_DEV;
         cnt_q <= 4'h0;
         drv_q <= 1'b0;
      end
      else if (scl_rise)
      begin
         // Sample data while the clock is high
         case (state_q)
            S_DEV, S_WA, S_WR, S_RD:
            begin
               shift_q <= {shift_q[6:0], sda_s};
               cnt_q <= cnt_q + 4'h1;
            end
            S_RACK:
            begin
               // Master acknowledge continues a sequential read
               if (!sda_s)
               begin
                  state_q <= S_RD;
                  cnt_q <= 4'h0;
                  tx_q <= mem_q[ptr_q];
               end
               else
                  state_q <= S_IDLE;
            end
            default:
               cnt_q <= cnt_q;
         endcase
      end
      else if (scl_fall)
      begin
         // Change the line only while the clock is low [R9]
         case (state_q)
            S_DEV:
            begin
               if (cnt_q == 4'h8)
               begin
                  // Busy programming: no acknowledge so the master can poll [R19]
                  if (dev_match && !busy)
                  begin
                     state_q <= S_DACK;
                     drv_q <= 1'b1;
                     rw_q <= shift_q[0];
                  end
                  else
                     state_q <= S_IDLE;
               end
            end
            S_DACK:
            begin
               cnt_q <= 4'h0;
               if (rw_q)
               begin
                  state_q <= S_RD;
                  tx_q <= mem_q[ptr_q];
                  drv_q <= ~mem_q[ptr_q][7];
               end
               else
               begin
                  state_q <= S_WA;
                  drv_q <= 1'b0;
               end
            end
            S_WA:
            begin
               if (cnt_q == 4'h8)
               begin
                  ptr_q <= shift_q;
                  state_q <= S_WACK;
                  drv_q <= 1'b1;
               end
            end
            S_WACK:
            begin
               cnt_q <= 4'h0;
               state_q <= S_WR;
               drv_q <= 1'b0;
            end
            S_WR:
            begin
               if (cnt_q == 4'h8)
               begin
                  // Only the low four bits advance, wrapping in the page [R2] [R18]
                  ptr_q <= {ptr_q[7:4], ptr_q[3:0] + 4'h1};
                  state_q <= S_WACK;
                  // Acknowledged even when protected [R20]
                  drv_q <= 1'b1;
               end
            end
            S_RD:
            begin
               if (cnt_q == 4'h8)
               begin
                  // Release for the master's acknowledge; pointer wraps the array
                  ptr_q <= ptr_q + 8'h01;
                  state_q <= S_RACK;
                  drv_q <= 1'b0;
               end
               else if (cnt_q == 4'h0)
                  drv_q <= ~tx_q[7];
               else
               begin
                  drv_q <= ~tx_q[6];
                  tx_q <= {tx_q[6:0], 1'b0};
               end
            end
            default:
               drv_q <= 1'b0;
         endcase
      end
   end

   // Page buffer collects bytes; a new address phase or protection drops them [R3] [R5] [R20]
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         vld_q <= '0;
         page_q <= 4'h0;
      end
      else if (done || (stop_c && wp_s))
         vld_q <= '0;
      else if (en && !stop_c && !start_c && scl_fall && cnt_q == 4'h8)
      begin
         if (state_q == S_WA)
            vld_q <= '0;
         else if (state_q == S_WR)
         begin
            // Later bytes at a wrapped position overwrite earlier ones [R18]
            vld_q[ptr_q[3:0]] <= 1'b1;
            page_q <= ptr_q[7:4];
         end
      end
   end

   // Buffer data, no reset needed since the valid mask guards it
   always_ff @(posedge pclk)
   begin
      if (state_q == S_WR && scl_fall && cnt_q == 4'h8)
         buf_q[ptr_q[3:0]] <= shift_q;
   end

   // Commit at the end of the timed cycle, only bytes actually sent [R1] [R3]
   always_ff @(posedge pclk)
   begin
      for (int i = 0; i < PAGE_BYTES; i++)
      begin
         if (done && vld_q[i])
            mem_q[{page_q, 4'(i)}] <= buf_q[i];
      end
   end

   // Open-drain data line: only ever pulled low [R9]
   assign sda_out = 1'b0;
   assign sda_oe = drv_q;
   assign standby = (state_q == S_IDLE) && !busy;

   // Control register; enable gates the bus machine
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl_q <= CTRL_RESET;
      else if (psel && penable && pwrite && paddr == CTRL_OFS)
         ctrl_q <= {31'h0, pwdata[CTRL_EN_BIT]};
   end

   // Read data captured in the setup phase, held through access
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (psel && !penable)
      begin
         case (paddr)
            STATUS_OFS:
            begin
               prdata <= 32'h0000_0000;
               prdata[ST_BUSY_BIT] <= busy;
               prdata[ST_WP_BIT] <= wp_s;
               prdata[ST_STBY_BIT] <= standby;
               prdata[ST_SEL_LSB +: 3] <= sel_s;
               prdata[ST_PTR_LSB +: 8] <= ptr_q;
            end
            CTRL_OFS:
               prdata <= ctrl_q;
            default:
               prdata <= 32'h0000_0000;
         endcase
      end
   end

   // Zero-wait slave; unmapped addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = psel && penable && (paddr != STATUS_OFS) && (paddr != CTRL_OFS);

   // Checks, all in the pclk domain
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Helper: cycles spent busy in the current cycle
   logic [PROG_CNT_W-1:0] busy_cnt_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         busy_cnt_q <= '0;
      else if (!busy)
         busy_cnt_q <= '0;
      else
         busy_cnt_q <= busy_cnt_q + 1'b1;
   end

   // Address byte complete and accepted
   sequence s_dev_byte;
      state_q == S_DEV && scl_fall && cnt_q == 4'h8 && !start_c && !stop_c && en;
   endsequence
   sequence s_dev_acked;
      state_q == S_DACK && drv_q;
   endsequence

   a_drive_states: assert property ( // [R9]
      sda_oe |-> state_q inside {S_DACK, S_WACK, S_RD})
      else $error("data line driven outside an acknowledge or read");
   a_busy_no_ack: assert property ( // [R19]
      s_dev_byte and busy |=> !sda_oe && state_q == S_IDLE)
      else $error("address acknowledged while programming");
   a_addr_match: assert property ( // [R16]
      s_dev_byte ##1 s_dev_acked |-> $past(dev_match, 1) && rw_q == $past(shift_q[0], 1))
      else $error("acknowledged a foreign slave address");
   a_prog_bound: assert property ( // [R4]
      busy_cnt_q <= PROG_CNT_W'(PROG_CYC))
      else $error("programming cycle exceeds its time");
   a_wp_no_prog: assert property ( // [R5]
      $rose(busy) |-> !$past(wp_s))
      else $error("programming started while protected");
   a_stop_start: assert property ( // [R17]
      $rose(busy) |-> $past(stop_c) && $past(vld_q) != '0)
      else $error("programming began without a Stop after writes");
   a_page_wrap: assert property ( // [R18]
      state_q == S_WR && scl_fall && cnt_q == 4'h8 && en && !stop_c && !start_c
      |=> ptr_q[7:4] == $past(ptr_q[7:4]) && ptr_q[3:0] == $past(ptr_q[3:0]) + 4'h1)
      else $error("page write pointer left its page");
   a_stop_standby: assert property ( // [R12]
      stop_c && !prog_start && !busy |=> standby)
      else $error("no standby after Stop while idle");
endmodule : eeprom_core
`default_nettype wire

/* sim/twi_master_model.sv */
// Purpose: Behavioural two-wire bus master facing the slave core
// Assumes: pclk paces every change; half a bit is four pclk (200 ns bit)
// Notes: Clock stands high between frames; a released data line reads high
`timescale 1ns/1ps
`default_nettype none
module twi_master_model (
   // Pacing clock
   input wire logic pclk,
   // Bus wires, data pulled low only
   output logic scl,
   output logic sda_low,
   input wire logic sda
);
   // Idle bus: both lines released
   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // Wait a number of pclk edges
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask : tick
   // Start or repeated start: data falls while clock is high
   task automatic start();
      sda_low <= 1'b0;
      tick(4);
      scl <= 1'b1;
      tick(4);
      sda_low <= 1'b1;
      tick(4);
      scl <= 1'b0;
      tick(4);
   endtask : start
   // Stop: data rises while clock is high, clock then stands high
   task automatic stop();
      sda_low <= 1'b1;
      tick(4);
      scl <= 1'b1;
      tick(4);
      sda_low <= 1'b0;
      tick(4);
   endtask : stop
   // One bit out, changed only while clock is low
   task automatic wbit(input logic b);
      sda_low <= ~b;
      tick(2);
      scl <= 1'b1;
      tick(4);
      scl <= 1'b0;
      tick(2);
   endtask : wbit
   // One bit in, line released, sampled late in the high phase
   task automatic rbit(output logic b);
      sda_low <= 1'b0;
      tick(2);
      scl <= 1'b1;
      tick(3);
      b = sda;
      tick(1);
      scl <= 1'b0;
      tick(2);
   endtask : rbit
   // Byte out MSB first, then the slave's acknowledge
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         wbit(d[i]);
      rbit(r);
      ack = ~r;
   endtask : wbyte
   // Byte in MSB first; last byte gets no acknowledge
   task automatic rbyte(input logic last, output logic [7:0] d);
      for (int i = 7; i >= 0; i--)
         rbit(d[i]);
      wbit(last);
   endtask : rbyte
endmodule : twi_master_model
`default_nettype wire

/* sim/two_wire_eeprom_slave_core_test.sv */
// Purpose: Self-checking bench of the two-wire EEPROM slave core
// Assumes: Short programming time parameter; seed fixed
// Notes: Bench array model only trusts bytes it has written itself
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin fails++; $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module two_wire_eeprom_slave_core_test;
   import eeprom_pkg::*;
   localparam int PCYC = 400; // Short enough for a quick run, long enough to poll
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sda_out, sda_oe;
   logic scl, m_low, wp, standby;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [2:0] sel; // Strap levels
   logic [7:0] mem_m [256]; // Expected array
   logic [7:0] nxt [256]; // Expected array once programming ends
   int fails = 0;
   int num_checks = 0;
   // Wired-AND data line with pull-up
   wire logic sda_line = ~((sda_oe & ~sda_out) | m_low);
   eeprom_core #(.PROG_CYC(PCYC)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
      .sda_oe(sda_oe), .device_select_bit0(sel[0]), .device_select_bit1(sel[1]),
      .device_select_bit2(sel[2]), .wp_in(wp), .standby(standby));
   twi_master_model bus (.pclk(pclk), .scl(scl), .sda_low(m_low), .sda(sda_line));
   // Clock
   initial
   begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   // Verdict
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : conclude
   // Hang guard
   initial
   begin
      repeat (100000) @(posedge pclk);
      fails++;
      conclude();
   end
   // Page-wrapped location of the i-th byte
   function automatic logic [7:0] page_at(input logic [7:0] b, input int i);
      return {b[7:4], b[3:0] + 4'(i)};
   endfunction : page_at
   // APB transfer; waits for pready under a bound
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         fails++;
         conclude();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Let an edge pass so a following call never reassigns psel in this step
      @(posedge pclk);
   endtask : apb
   // Start and slave address byte
   task automatic addr_byte(input logic rw, input logic [2:0] s, output logic ack);
      bus.start();
      bus.wbyte({TYPE_CODE, s[2], s[1], s[0], rw}, ack);
   endtask : addr_byte
   // Write frame without Stop; random data recorded as pending
   task automatic wr_seq(input logic [7:0] a, input int n, output logic ok);
      logic ack;
      logic [7:0] d;
      addr_byte(1'b0, sel, ok);
      bus.wbyte(a, ack);
      ok &= ack;
      for (int i = 0; i < n; i++)
      begin
         d = 8'($urandom);
         bus.wbyte(d, ack);
         ok &= ack;
         nxt[page_at(a, i)] = d;
      end
   endtask : wr_seq
   // Dummy write, repeated start, sixteen sequential reads
   task automatic rd_seq(input logic [7:0] a);
      logic ack;
      logic [7:0] d;
      addr_byte(1'b0, sel, ack);
      bus.wbyte(a, ack);
      addr_byte(1'b1, sel, ack);
      `CHK("read_ack", 1'b1, ack)
      for (int i = 0; i < 16; i++)
      begin
         bus.rbyte(i == 15, d);
         `CHK("read_data", mem_m[a + 8'(i)], d)
      end
      bus.stop();
   endtask : rd_seq
   // Stop, then busy and polling checks, then bounded wait for completion
   task automatic wait_prog();
      logic ack;
      logic err;
      logic [31:0] rd;
      realtime t0;
      int n;
      t0 = $realtime;
      bus.stop();
      bus.tick(4);
      `CHK("standby_busy", 1'b0, standby)
      apb(1'b0, STATUS_OFS, 32'h0, rd, err);
      `CHK("status_busy", 1'b1, rd[ST_BUSY_BIT])
      addr_byte(1'b0, sel, ack);
      bus.stop();
      `CHK("poll_nack", 1'b0, ack)
      n = 0;
      while (standby !== 1'b1 && n < PCYC)
      begin
         @(posedge pclk);
         n++;
      end
      // A programming cycle that never ends is a hang, not a late pass
      if (n >= PCYC)
      begin
         fails++;
         conclude();
      end
      `CHK("prog_time", 1'b1, ($realtime - t0) <= (PCYC + 30) * 25.0)
      mem_m = nxt;
   endtask : wait_prog
   // Main sequence
   initial
   begin
      logic ok;
      logic err;
      logic [31:0] rd;
      logic [7:0] base;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      presetn = 1'b0;
      wp = 1'b0;
      void'($urandom(96799));
      sel = 3'($urandom_range(7));
      repeat (3) @(posedge pclk);
      `CHK("standby_rst", 1'b1, standby)
      `CHK("sda_oe_rst", 1'b0, sda_oe)
      presetn <= 1'b1;
      bus.tick(10);
      apb(1'b0, STATUS_OFS, 32'h0, rd, err);
      `CHK("status_sel", {sel, wp}, {rd[ST_SEL_LSB+:3], rd[ST_WP_BIT]})
      `CHK("status_err", 1'b0, err)
      apb(1'b0, CTRL_OFS, 32'h0, rd, err);
      `CHK("ctrl_reset", CTRL_RESET, rd)
      apb(1'b0, 12'h008, 32'h0, rd, err);
      `CHK("unmapped_err", 1'b1, err)
      `CHK("unmapped_rd", 32'h0, rd)
      addr_byte(1'b0, sel ^ 3'h5, ok);
      bus.stop();
      `CHK("strap_miss", 1'b0, ok)
      base = {4'($urandom), 4'h0};
      nxt = mem_m;
      wr_seq(base, 16, ok);
      `CHK("page_ack", 1'b1, ok)
      `CHK("sda_out", 1'b0, sda_out)
      wait_prog();
      rd_seq(base);
      wr_seq(base | 8'h0E, 3, ok);
      wait_prog();
      rd_seq(base);
      wp <= 1'b1;
      bus.tick(4);
      wr_seq(base, 2, ok);
      `CHK("wp_ack", 1'b1, ok)
      bus.stop();
      bus.tick(6);
      `CHK("wp_standby", 1'b1, standby)
      rd_seq(base);
      wp <= 1'b0;
      wr_seq(base, 4, ok);
      presetn <= 1'b0;
      bus.tick(2);
      `CHK("rst_standby", 1'b1, standby)
      presetn <= 1'b1;
      bus.stop();
      bus.tick(6);
      `CHK("rst_nowrite", 1'b1, standby)
      rd_seq(base);
      apb(1'b1, CTRL_OFS, 32'h0, rd, err);
      addr_byte(1'b0, sel, ok);
      bus.stop();
      `CHK("disabled_nack", 1'b0, ok)
      // Re-enable with random upper bits; only the enable bit is kept
      apb(1'b1, CTRL_OFS, $urandom | (32'h1 << CTRL_EN_BIT), rd, err);
      apb(1'b0, CTRL_OFS, 32'h0, rd, err);
      `CHK("ctrl_en", 32'h1 << CTRL_EN_BIT, rd)
      // Move the straps to a new address and let them settle
      sel <= sel ^ 3'($urandom_range(7, 1));
      bus.tick(4);
      apb(1'b0, STATUS_OFS, 32'h0, rd, err);
      `CHK("status_sel2", sel, rd[ST_SEL_LSB+:3])
      addr_byte(1'b0, sel, ok);
      bus.stop();
      `CHK("new_strap_ack", 1'b1, ok)
      conclude();
   end
endmodule : two_wire_eeprom_slave_core_test
`default_nettype wire
